// [rtl/gbk_pkg.sv]
// shared constants, types and pointer helpers for the gamma register bank
package gbk_pkg;
  localparam int unsigned CH_N = 9;
  localparam int unsigned DW = 10;
  localparam logic [5:0] PTR_G8 = 6'h07;
  localparam logic [5:0] PTR_COM = 6'h12;
  localparam logic [5:0] PTR_REV = 6'h3c;
  localparam logic [5:0] PTR_ID = 6'h3d;
  localparam logic [5:0] PTR_MAXB = 6'h3f;
  localparam logic [3:0] IDX_COM = 4'h8;
  localparam int unsigned NVW_MSB = 15;
  localparam int unsigned NVW_LSB = 14;
  localparam logic [1:0] NVW_TAG = 2'h1;
  localparam logic [15:0] MAX_BANK_VAL = 16'h0001;
  localparam logic [15:0] REV_DEF = 16'h0001;
  localparam logic [15:0] ID_DEF = 16'h005a;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned BANK_REG_NS = 5000;
  localparam int unsigned BANK_OUT_NS = 10000;
  localparam int unsigned BANK_REG_CYC = BANK_REG_NS * CLK_MHZ / 1000;
  localparam int unsigned BANK_OUT_CYC = BANK_OUT_NS * CLK_MHZ / 1000;
  localparam int unsigned NV_PROG_NS = 250000;
  localparam int unsigned NV_PROG_CYC_DEF = (NV_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PROG_CW = 14;

  typedef logic [CH_N-1:0][DW-1:0] gbk_set_t;

  typedef enum logic [1:0] {
    GBK_WRITE = 2'h0,
    GBK_READ = 2'h1,
    GBK_ACQ_ONE = 2'h2,
    GBK_ACQ_ALL = 2'h3
  } gbk_op_t;

  typedef enum logic [2:0] {
    GBK_H_WRITE = 3'h0,
    GBK_H_READ = 3'h1,
    GBK_H_ACQ_ONE = 3'h2,
    GBK_H_ACQ_ALL = 3'h3,
    GBK_H_READ_NV = 3'h4,
    GBK_H_RESTORE = 3'h5
  } gbk_hop_t;

  function automatic logic ptr_ok(input logic [5:0] p);
    return (p <= PTR_G8) || (p == PTR_COM);
  endfunction

  function automatic logic [3:0] ptr_idx(input logic [5:0] p);
    return (p == PTR_COM) ? IDX_COM : p[3:0];
  endfunction

  function automatic logic [5:0] ptr_next(input logic [5:0] p);
    return (p == PTR_G8) ? PTR_COM : 6'(p + 6'h01);
  endfunction
endpackage

// [rtl/gbk_if.sv]
// link between the bus master and the gamma register bank
`timescale 1ns/1ps
interface gbk_if;
  import gbk_pkg::*;
  logic req_valid;
  logic req_ready;
  gbk_op_t req_op;
  logic [5:0] req_ptr;
  logic req_bank;
  logic req_seq;
  logic [15:0] req_wdata;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic rsp_err;
  logic bank_select_pin;

  modport dev(
    input req_valid, req_op, req_ptr, req_bank, req_seq, req_wdata, bank_select_pin,
    output req_ready, rsp_valid, rsp_data, rsp_err
  );
  modport host(
    output req_valid, req_op, req_ptr, req_bank, req_seq, req_wdata, bank_select_pin,
    input req_ready, rsp_valid, rsp_data, rsp_err
  );
endinterface

// [rtl/gbk_bank_store.sv]
// one curve: nonvolatile words plus their storage registers
`timescale 1ns/1ps
module gbk_bank_store
  import gbk_pkg::*;
#(
  parameter gbk_set_t NV_INIT = '0
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ld_all,
  input wire logic ld_one,
  input wire logic wr,
  input wire logic nv_wr,
  input wire logic [3:0] idx,
  input wire logic [DW-1:0] wdata,
  output gbk_set_t regs
);
  import gbk_pkg::*;

  typedef struct packed {
    gbk_set_t nv;
    gbk_set_t st;
  } gbk_store_t;

  gbk_store_t q;
  gbk_store_t d;

  always_comb
  begin
    d = q;
    if (ld_all)
    begin
      d.st = q.nv;
    end
    if (ld_one)
    begin
      d.st[idx] = q.nv[idx];
    end
    if (wr)
    begin
      d.st[idx] = wdata;
    end
    if (nv_wr)
    begin
      d.nv[idx] = wdata;
    end
  end

  // nonvolatile image comes back at power-on reset
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      q.nv <= NV_INIT;
      q.st <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign regs = q.st;
endmodule // gbk_bank_store

// [rtl/gbk_device.sv]
// gamma register bank: two curve sets, bank-select switching, acquire
//
// Functional notes
// - host acquires before reading stored values
// - acquire loads registers, and output levels only when the named bank is active
// - pointers 00-07 gamma, 12 common electrode
// - pin change updates all nine outputs together
// - pin level picks curve zero or one
// - registers switch well within five microseconds
// - two storage sets, each with its bank
// - power-on copies each bank into set
// - bus writes change curves used by switching
// - general acquire reloads only named bank
// - restoring both curves needs two acquires
// - pointer steps from 07 straight to 12
`timescale 1ns/1ps
module gbk_device
  import gbk_pkg::*;
#(
  parameter gbk_set_t NV_INIT0 = '0,
  parameter gbk_set_t NV_INIT1 = '0,
  parameter logic [15:0] REV_CODE = REV_DEF, // arbitrary value
  parameter logic [15:0] ID_CODE = ID_DEF, // arbitrary value
  parameter int unsigned NV_PROG_CYC = NV_PROG_CYC_DEF
)
(
  input wire logic core_clk,
  input wire logic rstn,
  gbk_if.dev lnk,
  output gbk_pkg::gbk_set_t gamma_level,
  output logic active_bank,
  output logic boot_done,
  output logic nv_busy
);
  import gbk_pkg::*;

  typedef enum logic [1:0] {
    GBK_BOOT = 2'b00,
    GBK_RUN = 2'b01,
    GBK_PROG = 2'b11
  } gbk_dev_st_t;

  typedef struct packed {
    gbk_dev_st_t st;
    logic bsel_s1;
    logic bsel_s2;
    logic bank;
    logic [5:0] ptr;
    logic [PROG_CW-1:0] prog_cnt;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
    gbk_set_t level;
  } gbk_dev_state_t;

  gbk_dev_state_t q;
  gbk_dev_state_t d;

  gbk_set_t set_q [2];
  logic [1:0] ld_all;
  logic [1:0] ld_one;
  logic [1:0] wr;
  logic [1:0] nv_wr;
  logic [3:0] idx;
  logic [DW-1:0] wdata;
  logic [5:0] ptr_sel;
  logic nv_req;

  for (genvar g = 0; g < 2; g++)
  begin : g_set
    gbk_bank_store #(
      .NV_INIT((g == 0) ? NV_INIT0 : NV_INIT1)
    ) u_store (
      .core_clk(core_clk),
      .rstn(rstn),
      .ld_all(ld_all[g]),
      .ld_one(ld_one[g]),
      .wr(wr[g]),
      .nv_wr(nv_wr[g]),
      .idx(idx),
      .wdata(wdata),
      .regs(set_q[g])
    );
  end

  always_comb
  begin
    d = q;
    d.rsp_valid = 1'b0;
    d.rsp_err = 1'b0;
    ld_all = 2'b00;
    ld_one = 2'b00;
    wr = 2'b00;
    nv_wr = 2'b00;
    // seq requests continue from the last pointer used
    ptr_sel = lnk.req_seq ? ptr_next(q.ptr) : lnk.req_ptr;
    idx = ptr_idx(ptr_sel);
    wdata = lnk.req_wdata[DW-1:0];
    nv_req = lnk.req_wdata[NVW_MSB:NVW_LSB] == NVW_TAG;

    d.bsel_s1 = lnk.bank_select_pin;
    d.bsel_s2 = q.bsel_s1;
    d.bank = q.bsel_s2;
    // outputs always follow the active set a cycle late: a reload shows a cycle after the registers, a pin edge four cycles later
    d.level = q.bank ? set_q[1] : set_q[0];

    unique case (q.st)
      GBK_BOOT:
      begin
        ld_all = 2'b11;
        d.st = GBK_RUN;
      end
      GBK_PROG:
      begin
        if (q.prog_cnt <= PROG_CW'(1))
        begin
          d.st = GBK_RUN;
        end
        d.prog_cnt = PROG_CW'(q.prog_cnt - PROG_CW'(1));
      end
      GBK_RUN:
      begin
        if (lnk.req_valid)
        begin
          d.rsp_valid = 1'b1;
          d.rsp_data = '0;
          d.ptr = ptr_sel;
          unique case (lnk.req_op)
            GBK_WRITE:
            begin
              if (!ptr_ok(ptr_sel) || (nv_req && lnk.req_seq))
              begin
                d.rsp_err = 1'b1;
              end
              else
              begin
                wr[q.bank] = 1'b1;
                if (nv_req)
                begin
                  // programming blocks the link for the full write time
                  nv_wr[q.bank] = 1'b1;
                  d.st = GBK_PROG;
                  d.prog_cnt = PROG_CW'(NV_PROG_CYC);
                end
              end
            end
            GBK_READ:
            begin
              if (ptr_ok(ptr_sel))
              begin
                d.rsp_data = {6'h00, set_q[q.bank][idx]};
              end
              else if (lnk.req_seq)
              begin
                d.rsp_err = 1'b1;
              end
              else if (ptr_sel == PTR_REV)
              begin
                d.rsp_data = REV_CODE;
              end
              else if (ptr_sel == PTR_ID)
              begin
                d.rsp_data = ID_CODE;
              end
              else if (ptr_sel == PTR_MAXB)
              begin
                d.rsp_data = MAX_BANK_VAL;
              end
              else
              begin
                d.rsp_err = 1'b1;
              end
            end
            GBK_ACQ_ONE:
            begin
              if (ptr_ok(ptr_sel))
              begin
                ld_one[lnk.req_bank] = 1'b1;
              end
              else
              begin
                d.rsp_err = 1'b1;
              end
            end
            GBK_ACQ_ALL:
            begin
              ld_all[lnk.req_bank] = 1'b1;
            end
          endcase
        end
      end
      default:
      begin
        d.st = GBK_BOOT;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign lnk.req_ready = q.st == GBK_RUN;
  assign lnk.rsp_valid = q.rsp_valid;
  assign lnk.rsp_data = q.rsp_data;
  assign lnk.rsp_err = q.rsp_err;
  assign gamma_level = q.level;
  assign active_bank = q.bank;
  assign boot_done = q.st != GBK_BOOT;
  assign nv_busy = q.st == GBK_PROG;
endmodule // gbk_device

// [rtl/gbk_host.sv]
// bus master end: issues register, acquire and compound requests
`timescale 1ns/1ps
module gbk_host
  import gbk_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  gbk_if.host lnk,
  input wire logic cmd_valid,
  input gbk_pkg::gbk_hop_t cmd_op,
  input wire logic [5:0] cmd_ptr,
  input wire logic cmd_bank,
  input wire logic cmd_seq,
  input wire logic [15:0] cmd_wdata,
  input wire logic bank_level,
  output logic cmd_ready,
  output logic done,
  output logic [15:0] rdata,
  output logic err
);
  import gbk_pkg::*;

  typedef enum logic [1:0] {
    GBK_H_IDLE = 2'b00,
    GBK_H_ISSUE = 2'b01,
    GBK_H_WAIT = 2'b11
  } gbk_host_st_t;

  typedef struct packed {
    gbk_host_st_t st;
    gbk_hop_t hop;
    gbk_op_t op;
    logic [5:0] ptr;
    logic bank;
    logic seq;
    logic [15:0] wdata;
    logic pend;
    logic done;
    logic [15:0] rdata;
    logic err;
    logic pin;
  } gbk_host_state_t;

  gbk_host_state_t q;
  gbk_host_state_t d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.pin = bank_level;
    unique case (q.st)
      GBK_H_IDLE:
      begin
        if (cmd_valid)
        begin
          d.hop = cmd_op;
          d.ptr = cmd_ptr;
          d.bank = cmd_bank;
          d.seq = cmd_seq;
          d.wdata = cmd_wdata;
          d.pend = 1'b0;
          d.st = GBK_H_ISSUE;
          unique case (cmd_op)
            GBK_H_WRITE: d.op = GBK_WRITE;
            GBK_H_READ: d.op = GBK_READ;
            GBK_H_ACQ_ONE: d.op = GBK_ACQ_ONE;
            GBK_H_ACQ_ALL: d.op = GBK_ACQ_ALL;
            GBK_H_READ_NV:
            begin
              d.op = GBK_ACQ_ONE;
              d.seq = 1'b0;
              d.pend = 1'b1;
            end
            GBK_H_RESTORE:
            begin
              d.op = GBK_ACQ_ALL;
              d.bank = 1'b0;
              d.pend = 1'b1;
            end
            default:
            begin
              d.st = GBK_H_IDLE;
            end
          endcase
        end
      end
      GBK_H_ISSUE:
      begin
        if (lnk.req_ready)
        begin
          d.st = GBK_H_WAIT;
        end
      end
      GBK_H_WAIT:
      begin
        if (lnk.rsp_valid)
        begin
          if (q.pend && !lnk.rsp_err)
          begin
            d.pend = 1'b0;
            d.st = GBK_H_ISSUE;
            if (q.hop == GBK_H_READ_NV)
            begin
              d.op = GBK_READ;
            end
            else
            begin
              d.bank = 1'b1;
            end
          end
          else
          begin
            d.done = 1'b1;
            d.rdata = lnk.rsp_data;
            d.err = lnk.rsp_err;
            d.st = GBK_H_IDLE;
          end
        end
      end
      default:
      begin
        d.st = GBK_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign lnk.req_valid = q.st == GBK_H_ISSUE;
  assign lnk.req_op = q.op;
  assign lnk.req_ptr = q.ptr;
  assign lnk.req_bank = q.bank;
  assign lnk.req_seq = q.seq;
  assign lnk.req_wdata = q.wdata;
  assign lnk.bank_select_pin = q.pin;
  assign cmd_ready = q.st == GBK_H_IDLE;
  assign done = q.done;
  assign rdata = q.rdata;
  assign err = q.err;
endmodule // gbk_host

// [tb/gbk_asserts.sv]
// link checker for the gamma bank pair
`timescale 1ns/1ps
module gbk_asserts
  import gbk_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input gbk_pkg::gbk_op_t req_op,
  input wire logic [5:0] req_ptr,
  input wire logic req_seq,
  input wire logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_err,
  input wire logic bank_select_pin
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic tk;
  logic chp;
  assign tk = req_valid && req_ready;
  assign chp = (req_ptr <= 6'h07) || (req_ptr == 6'h12);
  a_answer_next: assert property (tk |=> rsp_valid)
    else $error("no answer after request");
  a_answer_cause: assert property (rsp_valid |-> $past(tk))
    else $error("answer without request");
  a_upper_zero: assert property (tk && req_op == GBK_READ && !req_seq && chp
    |=> !rsp_err && rsp_data[15:10] == 6'h00) else $error("read upper bits set");
  a_bad_ptr: assert property (tk && req_op inside {GBK_WRITE, GBK_ACQ_ONE} && !chp
    |=> rsp_err) else $error("bad pointer accepted");
  a_read_unmapped: assert property (tk && req_op == GBK_READ && !req_seq && !chp
    && req_ptr < 6'h3c |=> rsp_err) else $error("unmapped read accepted");
  a_highest_bank_info_read: assert property (tk && req_op == GBK_READ && req_ptr == PTR_MAXB
    && !req_seq |=> rsp_data == MAX_BANK_VAL) else $error("bank info wrong");
  a_acq_all_ok: assert property (tk && req_op == GBK_ACQ_ALL |=> !rsp_err)
    else $error("acquire refused");
  a_write_ok: assert property (tk && req_op == GBK_WRITE && !req_seq && chp
    |=> !rsp_err) else $error("good write refused");
  a_nv_busy: assert property (tk && req_op == GBK_WRITE && chp && !req_seq
    && req_wdata[15:14] == 2'b01 |=> !req_ready [*7]) else $error("link open while programming");
  c_read: cover property (tk && req_op == GBK_READ && req_seq);
  c_acq: cover property (tk && req_op == GBK_ACQ_ALL);
  c_pin: cover property ($changed(bank_select_pin));
endmodule // gbk_asserts

// [tb/gbk_tb.sv]
// self-checking bench for the gamma bank pair
`timescale 1ns/1ps
module gbk_tb;
  import gbk_pkg::*;
  function automatic gbk_set_t mk(input int s);
    gbk_set_t r;
    for (int i = 0; i < CH_N; i++) r[i] = 10'(s + i * 37);
    return r;
  endfunction
  localparam gbk_set_t NV0 = mk(5);
  localparam gbk_set_t NV1 = mk(600);
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_bank, cmd_seq, bank_level, cmd_ready, done, err, active_bank;
  logic boot_done, nv_busy;
  gbk_hop_t cmd_op;
  logic [5:0] cmd_ptr;
  logic [15:0] cmd_wdata, rdata;
  gbk_set_t gamma_level, m[2], nv[2];
  int bad_count, cmp_count, cyc;
  gbk_if lnk();
  gbk_device #(.NV_INIT0(NV0), .NV_INIT1(NV1), .NV_PROG_CYC(8)) u_gbk_device(.core_clk,
    .rstn, .lnk, .gamma_level, .active_bank, .boot_done, .nv_busy);
  gbk_host u_gbk_host(.core_clk, .rstn, .lnk, .cmd_valid, .cmd_op, .cmd_ptr, .cmd_bank,
    .cmd_seq, .cmd_wdata, .bank_level, .cmd_ready, .done, .rdata, .err);
  gbk_asserts u_gbk_asserts(.core_clk, .rstn, .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req_op(lnk.req_op), .req_ptr(lnk.req_ptr),
    .req_seq(lnk.req_seq), .req_wdata(lnk.req_wdata), .rsp_valid(lnk.rsp_valid),
    .rsp_data(lnk.rsp_data), .rsp_err(lnk.rsp_err), .bank_select_pin(lnk.bank_select_pin));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    if (g !== e)
    begin
      $display("wrong value at %0t: got %h want %h", $time, g, e);
      bad_count++;
    end
    cmp_count++;
  endtask
  task automatic cmd(gbk_hop_t o, logic [5:0] p, logic b, logic s, logic [15:0] w);
    @(posedge core_clk);
    cmd_op <= o;
    cmd_ptr <= p;
    cmd_bank <= b;
    cmd_seq <= s;
    cmd_wdata <= w;
    cmd_valid <= 1'b1;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(negedge core_clk);
    while (done !== 1'b1) @(negedge core_clk);
  endtask
  task automatic ck(input logic [15:0] e, input logic ee);
    chk(rdata, e);
    chk(16'(err), 16'(ee));
  endtask
  task automatic sw(input logic b);
    int n;
    n = 0;
    @(posedge core_clk);
    bank_level <= b;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (gamma_level !== m[b] && n < 300);
    chk(16'(n <= BANK_REG_CYC), 16'h1);
    chk(16'(active_bank), 16'(b));
  endtask
  initial
  begin
    int i;
    logic b;
    logic [15:0] w;
    logic [5:0] p;
    logic [5:0] bad_p [3];
    cmd_valid = 1'b0;
    cmd_op = GBK_H_WRITE;
    cmd_ptr = 6'h00;
    cmd_bank = 1'b0;
    cmd_seq = 1'b0;
    cmd_wdata = 16'h0000;
    bank_level = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(32'ha8c8caeb));
    m[0] = NV0;
    m[1] = NV1;
    nv = m;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk(16'(gamma_level === NV0), 16'h1);
    chk(16'(boot_done), 16'h1);
    cmd(GBK_H_READ, 6'h00, 1'b0, 1'b0, 16'h0);
    ck({6'h00, m[0][0]}, 1'b0);
    for (i = 1; i < 9; i++)
    begin
      cmd(GBK_H_READ, 6'h00, 1'b0, 1'b1, 16'h0);
      ck({6'h00, m[0][i]}, 1'b0);
    end
    // one step past the common electrode leaves the channel map
    cmd(GBK_H_READ, 6'h00, 1'b0, 1'b1, 16'h0);
    chk(16'(err), 16'h1);
    for (int k = 0; k < 24; k++)
    begin
      b = k[3];
      if (k % 8 == 0) sw(b);
      i = $urandom_range(8);
      w = 16'($urandom);
      if (w[15:14] == 2'b01) w[15] = 1'b1;
      p = (i == 8) ? 6'h12 : 6'(i);
      cmd(GBK_H_WRITE, p, 1'b0, 1'b0, w);
      chk(16'(err), 16'h0);
      m[b][i] = w[9:0];
      cmd(GBK_H_READ, p, 1'b0, 1'b0, 16'h0);
      ck({6'h00, m[b][i]}, 1'b0);
      chk(16'(gamma_level === m[b]), 16'h1);
    end
    bad_p[0] = 6'h08;
    bad_p[1] = 6'h11;
    bad_p[2] = PTR_REV;
    foreach (bad_p[j])
    begin
      cmd(GBK_H_WRITE, bad_p[j], 1'b0, 1'b0, 16'h0001);
      chk(16'(err), 16'h1);
    end
    cmd(GBK_H_READ, 6'h20, 1'b0, 1'b0, 16'h0);
    chk(16'(err), 16'h1);
    cmd(GBK_H_READ, PTR_MAXB, 1'b0, 1'b0, 16'h0);
    ck(MAX_BANK_VAL, 1'b0);
    cmd(GBK_H_READ, PTR_REV, 1'b0, 1'b0, 16'h0);
    ck(REV_DEF, 1'b0);
    cmd(GBK_H_READ, PTR_ID, 1'b0, 1'b0, 16'h0);
    ck(ID_DEF, 1'b0);
    sw(1'b1);
    cmd(GBK_H_ACQ_ALL, 6'h00, 1'b0, 1'b0, 16'h0);
    m[0] = nv[0];
    chk(16'(gamma_level === m[1]), 16'h1);
    sw(1'b0);
    sw(1'b1);
    cmd(GBK_H_READ_NV, 6'h03, 1'b1, 1'b0, 16'h0);
    m[1][3] = nv[1][3];
    ck({6'h00, nv[1][3]}, 1'b0);
    w = {6'h10, 10'($urandom)};
    cmd(GBK_H_WRITE, 6'h05, 1'b0, 1'b0, w);
    nv[1][5] = w[9:0];
    chk(16'(nv_busy), 16'h1);
    // register takes the programmed word at once
    cmd(GBK_H_READ, 6'h05, 1'b0, 1'b0, 16'h0);
    ck({6'h00, w[9:0]}, 1'b0);
    cmd(GBK_H_WRITE, 6'h05, 1'b0, 1'b0, 16'h0123);
    cmd(GBK_H_RESTORE, 6'h00, 1'b0, 1'b0, 16'h0);
    m = nv;
    chk(16'(gamma_level === m[1]), 16'h1);
    sw(1'b0);
    cmd(GBK_H_WRITE, 6'h00, 1'b0, 1'b0, 16'h03ff);
    cmd(GBK_H_ACQ_ONE, 6'h00, 1'b0, 1'b0, 16'h0);
    chk(16'(gamma_level === m[0]), 16'h1);
    results();
  end
endmodule // gbk_tb
